// ### bdp_pkg.sv
// Package for the two-bit and four-bit bidirectional port block
`default_nettype none
package bdp_pkg;
    // I/O module addresses on the nibble bus
    localparam logic [3:0] ADDR_DUAL_PORT = 4'h1;
    localparam logic [3:0] ADDR_QUAD_PORT = 4'h2;
    localparam logic [3:0] ADDR_AUX_SWITCH = 4'h8;
    // Reset values
    localparam logic [3:0] QUAD_DATA_RST = 4'hF;
    localparam logic [3:0] QUAD_DIR_RST = 4'hF;
    localparam logic [1:0] DUAL_LATCH_RST = 2'h3;
    localparam logic [3:0] AUX_SEL_RST = 4'hF;
    // Bit positions of the two-bit port inside the nibble
    localparam int DUAL_BIT_LO = 0;
    localparam int DUAL_BIT_HI = 3;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;

    // One CPU I/O bus access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [3:0] wdata;
    } bdp_io_req_t;

    // Pad control for one four-bit port
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } bdp_pad4_t;

    // Map two-bit port onto the nibble lanes
    function automatic logic [3:0] dual_to_nibble(input logic [1:0] v);
        logic [3:0] n;
        n = NIBBLE_ZERO;
        n[DUAL_BIT_LO] = v[0];
        n[DUAL_BIT_HI] = v[1];
        return n;
    endfunction
endpackage
`default_nettype wire

// ### bdp_dual_port.sv
// Two-bit port with direction switched automatically by IN and OUT
`default_nettype none
module bdp_dual_port (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wr_hit,
    input wire logic rd_hit,
    input wire logic [3:0] wdata,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe_n,
    output logic [3:0] rdata
);
    logic [1:0] latch_r;
    logic out_mode_r;
    logic [1:0] pin_s;

    // Pins sampled by a register so a read returns their settled level
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= bdp_pkg::DUAL_LATCH_RST;
            out_mode_r <= 1'h0;
            pin_s <= bdp_pkg::DUAL_LATCH_RST;
        end else begin
            pin_s <= pin_in;
            if (wr_hit) begin
                latch_r <= {wdata[bdp_pkg::DUAL_BIT_HI], wdata[bdp_pkg::DUAL_BIT_LO]};
                out_mode_r <= 1'h1;
            end else if (rd_hit) begin
                out_mode_r <= 1'h0;
            end
        end
    end

    // Whole port shares one enable; only bits 0 and 3 exist
    assign pin_out = latch_r;
    assign pin_oe_n = {2{~out_mode_r}};
    // Pins, not latch; first read after output may still see the latch level
    assign rdata = bdp_pkg::dual_to_nibble(pin_s);

    // Direction follows the last IN or OUT to this port
    a_dual_out_switch: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_hit |=> (pin_oe_n == 2'h0) && (pin_out == $past({wdata[3], wdata[0]})))
        else $error("dual port not driving written data");
    a_dual_in_switch: assert property (@(posedge core_clk) disable iff (!resetn)
        (rd_hit && !wr_hit) |=> (pin_oe_n == 2'h3))
        else $error("dual port not released on input");
    a_dual_rd_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        (rdata[1] == 1'h0) && (rdata[2] == 1'h0))
        else $error("dual port drives missing bits");
endmodule
`default_nettype wire

// ### bdp_ports.sv
// Top of the two-bit and four-bit bidirectional ports on the nibble I/O bus
// Function
// - Two-bit port uses only nibble bits 0 and 3.
// - Four-bit port has four data latches and pins.
// - Data at primary register, direction at auxiliary; four-bit port address 2.
// - OUT turns two-bit port to output, IN turns it to input.
// - Written two-bit data latched on the OUT clock and driven at the pads one clock later.
// - Reset sets two-bit latches to one and port to input.
// - IN on two-bit port returns pin levels, not latches.
// - Direction bit n governs pin n; one input, zero output.
// - Four-bit direction register resets to all ones.
// - Four-bit data read returns pin levels even for outputs.
// - Strong pull-up on four-bit pin 0 during reset.
// - Four-bit pin 0 pull-down disabled during reset and until the first clock after it.
// - Aux switch write selects auxiliary register for the next access only, if that access is to the selected address.
`default_nettype none
module bdp_ports (
    input wire logic core_clk,
    input wire logic resetn,
    input wire bdp_pkg::bdp_io_req_t io_req,
    output logic [3:0] io_rdata,
    output logic io_rvalid,
    input wire logic [1:0] dual_pin_in,
    output logic [1:0] dual_pin_out,
    output logic [1:0] dual_pin_oe_n,
    input wire logic [3:0] quad_pin_in,
    output bdp_pkg::bdp_pad4_t quad_pad,
    output logic quad_pin0_test_enable,
    output logic quad_pin0_pulldown_off
);
    logic [3:0] quad_port_data_reg;
    logic [3:0] quad_port_direction_reg;
    logic [3:0] aux_sel_r;
    logic [3:0] quad_pin_s;
    logic [3:0] io_rdata_r;
    logic io_rvalid_r;
    logic [1:0] dual_out_w;
    logic [1:0] dual_oe_w;
    logic [3:0] dual_rdata_w;
    logic reset_phase_r;

    // Address decode; aux_sel holds the module picked by the switch
    wire aux_active = (aux_sel_r == io_req.addr);
    wire any_access = io_req.wr | io_req.rd;
    wire asw_wr = io_req.wr && (io_req.addr == bdp_pkg::ADDR_AUX_SWITCH);
    wire quad_hit = (io_req.addr == bdp_pkg::ADDR_QUAD_PORT);
    wire quad_data_wr = io_req.wr && quad_hit && !aux_active;
    wire quad_dir_wr = io_req.wr && quad_hit && aux_active;
    wire quad_data_rd = io_req.rd && quad_hit && !aux_active;
    wire dual_hit = (io_req.addr == bdp_pkg::ADDR_DUAL_PORT);
    // Two-bit port has no auxiliary register, so any write reaches the latch and any read returns the pins
    wire dual_wr = io_req.wr && dual_hit;
    wire dual_rd = io_req.rd && dual_hit;

    // Read mux; direction register is write-only and reads as zero
    wire [3:0] rd_mux = quad_data_rd ? quad_pin_s :
                        dual_rd ? dual_rdata_w : bdp_pkg::NIBBLE_ZERO;

    // Pad drive: direction bit one means released
    wire [3:0] quad_oe_n_nxt = quad_port_direction_reg;

    bdp_dual_port u_dual (
        .core_clk(core_clk),
        .resetn(resetn),
        .wr_hit(dual_wr),
        .rd_hit(dual_rd),
        .wdata(io_req.wdata),
        .pin_in(dual_pin_in),
        .pin_out(dual_out_w),
        .pin_oe_n(dual_oe_w),
        .rdata(dual_rdata_w)
    );

    // Four-bit port registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quad_port_data_reg <= bdp_pkg::QUAD_DATA_RST;
            quad_port_direction_reg <= bdp_pkg::QUAD_DIR_RST;
        end else begin
            // Never both at once: the aux select steers a write to one of them
            if (quad_data_wr) begin
                quad_port_data_reg <= io_req.wdata;
            end
            if (quad_dir_wr) begin
                quad_port_direction_reg <= io_req.wdata;
            end
        end
    end

    // Aux switch: a select lasts for one following access to any module
    // Clearing on any access keeps a stale select from hitting a later write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aux_sel_r <= bdp_pkg::AUX_SEL_RST;
        end else if (asw_wr) begin
            aux_sel_r <= io_req.wdata;
        end else if (any_access) begin
            aux_sel_r <= bdp_pkg::AUX_SEL_RST;
        end
    end

    // Pin sampling and registered read return
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quad_pin_s <= bdp_pkg::QUAD_DATA_RST;
            io_rdata_r <= bdp_pkg::NIBBLE_ZERO;
            io_rvalid_r <= 1'h0;
        end else begin
            quad_pin_s <= quad_pin_in;
            io_rdata_r <= rd_mux;
            io_rvalid_r <= io_req.rd;
        end
    end

    // Reset phase flag: set under reset, cleared on the first clock after
    // A flop keeps the pin 0 steering glitch-free, at the cost of one extra cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reset_phase_r <= 1'h1;
        end else begin
            reset_phase_r <= 1'h0;
        end
    end

    // Outputs, all registered
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quad_pad.out <= bdp_pkg::QUAD_DATA_RST;
            quad_pad.oe_n <= bdp_pkg::QUAD_DIR_RST;
            dual_pin_out <= bdp_pkg::DUAL_LATCH_RST;
            dual_pin_oe_n <= bdp_pkg::DUAL_LATCH_RST;
        end else begin
            quad_pad.out <= quad_port_data_reg;
            quad_pad.oe_n <= quad_oe_n_nxt;
            dual_pin_out <= dual_out_w;
            dual_pin_oe_n <= dual_oe_w;
        end
    end

    assign io_rdata = io_rdata_r;
    assign io_rvalid = io_rvalid_r;
    // Pull-up and pull-down steering come from the reset-phase flop
    assign quad_pin0_test_enable = reset_phase_r;
    assign quad_pin0_pulldown_off = reset_phase_r;

    sequence s_aux_select;
        io_req.wr && (io_req.addr == bdp_pkg::ADDR_AUX_SWITCH)
            && (io_req.wdata == bdp_pkg::ADDR_QUAD_PORT);
    endsequence
    sequence s_quad_write;
        io_req.wr && (io_req.addr == bdp_pkg::ADDR_QUAD_PORT);
    endsequence
    // An access to another module in between must use up the select
    sequence s_other_access;
        (io_req.wr || io_req.rd) && (io_req.addr != bdp_pkg::ADDR_QUAD_PORT)
            && (io_req.addr != bdp_pkg::ADDR_AUX_SWITCH);
    endsequence

    // Aux switch routing
    a_aux_dir_write: assert property (@(posedge core_clk) disable iff (!resetn)
        s_aux_select ##1 s_quad_write |=> quad_port_direction_reg == $past(io_req.wdata))
        else $error("aux access did not reach direction");
    a_aux_cancel: assert property (@(posedge core_clk) disable iff (!resetn)
        s_aux_select ##1 s_other_access ##1 s_quad_write |=> $stable(quad_port_direction_reg))
        else $error("stale aux select reached direction");

    // Four-bit register and pad paths
    a_dir_drive_pad: assert property (@(posedge core_clk) disable iff (!resetn)
        quad_dir_wr |-> ##2 quad_pad.oe_n == $past(io_req.wdata, 2))
        else $error("direction not applied to pads");
    a_data_primary: assert property (@(posedge core_clk) disable iff (!resetn)
        quad_data_wr |=> quad_port_data_reg == $past(io_req.wdata)
            && $stable(quad_port_direction_reg))
        else $error("primary write hit wrong register");
    a_dir_keeps_data: assert property (@(posedge core_clk) disable iff (!resetn)
        quad_dir_wr |=> $stable(quad_port_data_reg))
        else $error("auxiliary write hit data register");
    a_data_to_pads: assert property (@(posedge core_clk) disable iff (!resetn)
        quad_data_wr |-> ##2 quad_pad.out == $past(io_req.wdata, 2))
        else $error("data latch not driven to pads");

    // Read return
    a_quad_readback: assert property (@(posedge core_clk) disable iff (!resetn)
        quad_data_rd |=> io_rvalid && io_rdata == $past(quad_pin_s))
        else $error("quad read not pin level");
    a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        io_req.rd |=> io_rvalid)
        else $error("read not answered");
    a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        (io_req.rd && !quad_data_rd && !dual_rd) |=> io_rdata == bdp_pkg::NIBBLE_ZERO)
        else $error("write-only or unmapped read not zero");

    // Reset and the reset-phase pin 0 steering
    a_reset_pullup: assert property (@(posedge core_clk)
        $rose(resetn) |-> quad_pin0_test_enable ##1 !quad_pin0_test_enable)
        else $error("pull-up not tied to reset phase");
    a_pulldown_off: assert property (@(posedge core_clk)
        quad_pin0_pulldown_off == quad_pin0_test_enable)
        else $error("pull-down not off in reset");
    a_pulldown_reset: assert property (@(posedge core_clk)
        $fell(resetn) |-> quad_pin0_pulldown_off && quad_pin0_test_enable)
        else $error("pin 0 steering not set by reset");
    a_dir_reset_input: assert property (@(posedge core_clk)
        $rose(resetn) |-> quad_port_direction_reg == bdp_pkg::QUAD_DIR_RST
            && quad_pad.oe_n == bdp_pkg::QUAD_DIR_RST)
        else $error("four-bit port not input after reset");
    a_dual_reset_input: assert property (@(posedge core_clk)
        $rose(resetn) |-> dual_pin_oe_n == bdp_pkg::DUAL_LATCH_RST
            && dual_pin_out == bdp_pkg::DUAL_LATCH_RST)
        else $error("two-bit port not input with latches high after reset");

    // Two-bit port as seen at the top pads
    a_dual_pad_out: assert property (@(posedge core_clk) disable iff (!resetn)
        dual_wr |-> ##2 dual_pin_oe_n == 2'h0)
        else $error("two-bit port not output after OUT");
    a_dual_latch: assert property (@(posedge core_clk) disable iff (!resetn)
        dual_wr |-> ##2 dual_pin_out == {$past(io_req.wdata[3], 2), $past(io_req.wdata[0], 2)})
        else $error("two-bit latch mismatch");
endmodule
`default_nettype wire

// ### bdp_pin_model.sv
// Pin-side model: outside levels merged with the pad drive of the block
`default_nettype none
module bdp_pin_model (
    input wire logic [1:0] dual_pin_out,
    input wire logic [1:0] dual_pin_oe_n,
    input wire bdp_pkg::bdp_pad4_t quad_pad,
    input wire logic [1:0] ext_dual,
    input wire logic [3:0] ext_quad,
    output logic [1:0] dual_pin_in,
    output logic [3:0] quad_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven pins show the latch; released pins fall to the outside pull level
    assign dual_pin_in = (dual_pin_out & ~dual_pin_oe_n) | (ext_dual & dual_pin_oe_n);
    assign quad_pin_in = (quad_pad.out & ~quad_pad.oe_n) | (ext_quad & quad_pad.oe_n);
endmodule
`default_nettype wire

// ### bdp_ports_tb.sv
// Self-checking bench for the two-bit and four-bit port block
`default_nettype none
module bdp_ports_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] QA = bdp_pkg::ADDR_QUAD_PORT;
    localparam logic [3:0] DA = bdp_pkg::ADDR_DUAL_PORT;
    localparam logic [3:0] SA = bdp_pkg::ADDR_AUX_SWITCH;
    // Both start high so that the first fall of each is a real event
    logic core_clk = 1'h1;
    logic resetn = 1'h1;
    bdp_pkg::bdp_io_req_t io_req = '0;
    logic [3:0] io_rdata, quad_pin_in;
    logic io_rvalid, quad_pin0_test_enable, quad_pin0_pulldown_off;
    logic [1:0] dual_pin_in, dual_pin_out, dual_pin_oe_n;
    bdp_pkg::bdp_pad4_t quad_pad;
    logic [1:0] ext_dual = 2'h1;
    logic [3:0] ext_quad = 4'h5;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    // Rows: direction, data, outside level, expected pin readback
    logic [3:0] rows [4][4] = '{'{4'h0, 4'hA, 4'h5, 4'hA}, '{4'hF, 4'h0, 4'h3, 4'h3},
        '{4'h5, 4'hC, 4'hA, 4'h8}, '{4'hA, 4'h3, 4'hF, 4'hB}};
    bdp_ports uut (.core_clk(core_clk), .resetn(resetn), .io_req(io_req),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .dual_pin_in(dual_pin_in),
        .dual_pin_out(dual_pin_out), .dual_pin_oe_n(dual_pin_oe_n),
        .quad_pin_in(quad_pin_in), .quad_pad(quad_pad),
        .quad_pin0_test_enable(quad_pin0_test_enable),
        .quad_pin0_pulldown_off(quad_pin0_pulldown_off));
    bdp_pin_model pins (.dual_pin_out(dual_pin_out), .dual_pin_oe_n(dual_pin_oe_n),
        .quad_pad(quad_pad), .ext_dual(ext_dual), .ext_quad(ext_quad),
        .dual_pin_in(dual_pin_in), .quad_pin_in(quad_pin_in));
    // Clock at 10 MHz
    always #50 core_clk = ~core_clk;
    // Cut a hang short well past the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus cycle per falling edge; an all-zero request is idle
    task automatic bus(input bdp_pkg::bdp_io_req_t r);
        @(negedge core_clk);
        io_req = r;
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        bus({1'h1, 1'h0, a, d});
    endtask
    // Answer stands only in the cycle after the taking edge, so look then
    task automatic rd(input logic [3:0] a, input logic [3:0] exp, input string nm);
        bus({1'h0, 1'h1, a, 4'h0});
        bus('0);
        chk("rvalid", 4'h1, {3'h0, io_rvalid});
        chk(nm, exp, io_rdata);
    endtask
    task automatic rst_chk();
        chk("dual_out", 4'h3, {2'h0, dual_pin_out});
        chk("dual_oe_n", 4'h3, {2'h0, dual_pin_oe_n});
        chk("quad_oe_n", 4'hF, quad_pad.oe_n);
        chk("test_en", 4'h1, {3'h0, quad_pin0_test_enable});
        chk("pd_off", 4'h1, {3'h0, quad_pin0_pulldown_off});
        chk("quad_out", 4'hF, quad_pad.out);
        chk("rvalid", 4'h0, {3'h0, io_rvalid});
    endtask
    initial begin
        @(negedge core_clk);
        resetn = 1'h0;
        repeat (12) @(negedge core_clk);
        rst_chk();
        resetn = 1'h1;
        repeat (2) @(negedge core_clk);
        chk("test_en", 4'h0, {3'h0, quad_pin0_test_enable});
        chk("pd_off", 4'h0, {3'h0, quad_pin0_pulldown_off});
        // Direction, data, pads and readback, writes back to back
        for (int i = 0; i < 4; i++) begin
            ext_quad = rows[i][2];
            wr(SA, QA);
            wr(QA, rows[i][0]);
            wr(QA, rows[i][1]);
            repeat (3) bus('0);
            chk("quad_oe_n", rows[i][0], quad_pad.oe_n);
            chk("quad_out", rows[i][1], quad_pad.out);
            rd(QA, rows[i][3], "quad_rd");
        end
        // A select used up by another access leaves the next write on data
        wr(SA, QA);
        wr(4'hF, 4'h0);
        wr(QA, 4'h6);
        repeat (3) bus('0);
        chk("quad_oe_n", rows[3][0], quad_pad.oe_n);
        chk("quad_out", 4'h6, quad_pad.out);
        // Direction register is write-only; unmapped space reads zero
        wr(SA, QA);
        rd(QA, 4'h0, "dir_rd");
        rd(4'hF, 4'h0, "unmapped");
        // Two-bit port: OUT turns it to output on nibble bits 0 and 3
        wr(DA, 4'h8);
        repeat (2) bus('0);
        chk("dual_oe_n", 4'h0, {2'h0, dual_pin_oe_n});
        chk("dual_out", 4'h2, {2'h0, dual_pin_out});
        // Precharge toward each outside pull (bit 0 up, bit 3 down), then read twice
        wr(DA, 4'h1);
        bus({1'h0, 1'h1, DA, 4'h0});
        repeat (3) bus('0);
        chk("dual_oe_n", 4'h3, {2'h0, dual_pin_oe_n});
        rd(DA, 4'h1, "dual_rd");
        // Reset again in mid-run
        resetn = 1'h0;
        @(negedge core_clk);
        rst_chk();
        resetn = 1'h1;
        repeat (2) @(negedge core_clk);
        chk("test_en", 4'h0, {3'h0, quad_pin0_test_enable});
        chk("quad_oe_n", 4'hF, quad_pad.oe_n);
        chk("dual_oe_n", 4'h3, {2'h0, dual_pin_oe_n});
        summarize();
    end
endmodule
`default_nettype wire
